// ### hdl/ppp_consts.svh
/*
  Constants of the parallel programming port: action codes, command bytes,
  lock bit positions, FIFO depth, programming times and reset values of fuse and lock bytes.
  Assumes a 10 MHz clock; included by bare name.
*/
`ifndef PPP_CONSTS_SVH
`define PPP_CONSTS_SVH
`define PPP_ACT_ADDR 2'h0
`define PPP_ACT_DATA 2'h1
`define PPP_ACT_CMD 2'h2
`define PPP_ACT_IDLE 2'h3
`define PPP_CMD_NOP 8'h00
`define PPP_CMD_WR_FLASH 8'h10
`define PPP_CMD_WR_EEPROM 8'h11
`define PPP_CMD_WR_FUSE 8'h40
`define PPP_CMD_WR_LOCK 8'h20
`define PPP_CMD_RD_FLASH 8'h02
`define PPP_CMD_RD_EEPROM 8'h03
`define PPP_CMD_RD_FUSELOCK 8'h04
`define PPP_CLK_MHZ 10
`define PPP_T_FLASH_US 4500
`define PPP_T_EEPROM_US 3600
`define PPP_T_FUSE_US 4500
`define PPP_FUSE_LO_RST 8'hFF
`define PPP_FUSE_HI_RST 8'hFF
`define PPP_FUSE_EX_RST 8'hFF
`define PPP_LOCK_RST 8'hFF
`define PPP_LOCK_LB1 0
`define PPP_LOCK_LB2 1
`define PPP_LOCK_BOOT_MASK 8'h3C
`define PPP_FIFO_DEPTH 8
`endif

// ### hdl/ppp_pkg.sv
/*
  Types of the parallel programming port.
  Assumes nothing of its surroundings.
*/
package ppp_pkg;
  typedef enum logic [2:0] {
    PPP_IDLE = 3'b000,
    PPP_WR_FLASH = 3'b001,
    PPP_WR_EEPROM = 3'b010,
    PPP_WR_FUSE = 3'b011,
    PPP_WR_LOCK = 3'b100
  } ppp_state_t;
  typedef struct packed {
    logic [15:0] data;
    logic [7:0] word;
  } ppp_latch_t;
endpackage

// ### hdl/ppp_fifo.sv
/*
  Synchronous FIFO with valid and ready on both sides.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module ppp_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 8
) (
  input wire logic clock,               // System clock.
  input wire logic reset,               // Synchronous reset.
  input wire logic in_valid,            // Write request.
  output logic in_ready,                // Room available.
  input wire logic [WIDTH-1:0] in_data, // Write data.
  output logic out_valid,               // Data available.
  input wire logic out_ready,           // Drain request.
  output logic [WIDTH-1:0] out_data     // Head word.
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] rd_ptr, wr_ptr, next_rd_ptr, next_wr_ptr;
  logic [AW:0] count, next_count;
  logic push, pop;
  always_comb begin
    push = in_valid && (count != (AW+1)'(DEPTH));
    pop = out_ready && (count != '0);
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    next_count = count + (AW+1)'(push) - (AW+1)'(pop);
  end
  always_ff @(posedge clock) begin
    if (reset) begin
      rd_ptr <= '0;
      wr_ptr <= '0;
      count <= '0;
    end else begin
      rd_ptr <= next_rd_ptr;
      wr_ptr <= next_wr_ptr;
      count <= next_count;
    end
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
endmodule // ppp_fifo

// ### hdl/ppp_port.sv
/*
  Parallel programming port: command, address and data loading, page buffers,
  flash and EEPROM page programming, fuse and lock writes, and read-back.
  Assumes all pins synchronous to clock and strobes held at least one cycle;
  the strobe rising (or falling for write) edge is detected on the clock.
  Flash and EEPROM are plain parameter-sized memories; erase is not modelled.
  A strobe must stay high and low for at least one clock period each.
*/
//Behaviour
//- Action select 10 loads command byte
//- Action select 00 loads address low/high
//- Action select 01 loads data low/high
//- Page latch copies data into buffer
//- Low bits word, upper bits page
//- Write flash command programs page, busy
//- Command zero is no-op, ends writes; here loads are refused while busy, so a NOP never ends a running write
//- Write EEPROM command programs EEPROM page
//- Read flash drives low/high word byte
//- Read EEPROM drives addressed EEPROM byte
//- Fuse write target chosen by byte selects
//- Fuse data zero programs, one erases
//- Lock write programs bits written zero
//- Lock mode 3 blocks boot lock programming
//- Lock bits never cleared by lock write
//- Fuse/lock read selected by byte selects
//- Ready/busy low while programming
//- Data bus driven only while output enable low; here drive is registered and follows output enable one cycle late
//- Command and address retained across operations
`timescale 1ns/1ps
`include "ppp_consts.svh"
module ppp_port #(
  parameter int FLASH_AW = 14,     // Flash word address width.
  parameter int FPAGE_W = 6,       // Word-in-page bits of a flash page.
  parameter int EE_AW = 10,        // EEPROM byte address width.
  parameter int EPAGE_W = 2,       // Byte-in-page bits of an EEPROM page.
  parameter int T_FLASH = `PPP_T_FLASH_US * `PPP_CLK_MHZ,
  parameter int T_EEPROM = `PPP_T_EEPROM_US * `PPP_CLK_MHZ,
  parameter int T_FUSE = `PPP_T_FUSE_US * `PPP_CLK_MHZ
) (
  input wire logic clock,             // 10 MHz clock.
  input wire logic reset,             // Synchronous reset.
  input wire logic action_select_hi,  // Action select bit 1.
  input wire logic action_select_lo,  // Action select bit 0.
  input wire logic action_strobe,     // Load strobe, acts on rising edge.
  input wire logic byte_select_one,   // Low/high byte select.
  input wire logic byte_select_two,   // Extended byte select.
  input wire logic page_latch_strobe, // Page buffer latch, rising edge.
  input wire logic write_n,           // Write strobe, active low.
  input wire logic output_enable_n,   // Output enable, active low.
  input wire logic [7:0] data_in,     // Data bus input.
  output logic [7:0] data_out,        // Data bus output.
  output logic data_oe,               // Data bus drive enable.
  output logic ready_busy_flag,       // 1 ready, 0 busy.
  output logic [7:0] fuse_low,        // Fuse low byte, 0 programmed.
  output logic [7:0] fuse_high,       // Fuse high byte.
  output logic [7:0] fuse_ext,        // Extended fuse byte.
  output logic [7:0] lock_bits        // Lock byte.
);
  // Flash and EEPROM contents, and the page buffers filled by the latch strobe.
  localparam int FDEPTH = 1 << FLASH_AW;
  localparam int EDEPTH = 1 << EE_AW;
  logic [15:0] flash [FDEPTH];
  logic [7:0] eeprom [EDEPTH];
  logic [15:0] fbuf [1 << FPAGE_W];
  logic [7:0] ebuf [1 << EPAGE_W];

  // Loaded command, address and data bytes; each persists until it is overwritten.
  logic [7:0] command, next_command, addr_lo, next_addr_lo, addr_hi, next_addr_hi;
  logic [7:0] dat_lo, next_dat_lo, dat_hi, next_dat_hi;
  logic strobe_q, latch_q, write_q;
  logic load_pulse, latch_pulse, write_pulse;
  // Programming state; the timer is wide enough for any programming time in cycles.
  ppp_pkg::ppp_state_t state, next_state;
  logic [31:0] timer, next_timer;
  logic [FPAGE_W:0] wcnt, next_wcnt;
  logic [1:0] fuse_sel, next_fuse_sel;
  logic [7:0] next_fuse_low, next_fuse_high, next_fuse_ext, next_lock_bits;
  logic [7:0] next_data_out;
  logic next_data_oe, next_ready;
  logic [15:0] word_addr;
  logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
  ppp_pkg::ppp_latch_t fifo_in, fifo_out;

  // The page copy moves one word per cycle; the counter and the array write share this test.
  // The programming time must be at least the page size, or the last words stay unwritten.
  // Both copies share one counter, so EPAGE_W must not exceed FPAGE_W.
  function automatic logic copying(
    input ppp_pkg::ppp_state_t cur,
    input ppp_pkg::ppp_state_t mode,
    input logic [FPAGE_W:0] cnt,
    input int size_w
  );
    return (cur == mode) && (cnt < (FPAGE_W+1)'(1 << size_w));
  endfunction

  assign word_addr = {addr_hi, addr_lo};
  // Strobes are level inputs seen on the clock; each pulse acts once, at its first sampled edge.
  // A pulse shorter than one clock period may be missed entirely.
  assign load_pulse = action_strobe && !strobe_q;
  assign latch_pulse = page_latch_strobe && !latch_q;
  assign write_pulse = !write_n && write_q;

  // Latched words travel through the FIFO so a burst of latches is never lost.
  assign fifo_in.data = {dat_hi, dat_lo};
  assign fifo_in.word = addr_lo;
  assign fifo_in_valid = latch_pulse && byte_select_one && fifo_in_ready;
  // The buffer side always drains, so the FIFO never fills; a latch is refused only when byte_select_one is low.
  assign fifo_out_ready = 1'b1;
  ppp_fifo #(.WIDTH(24), .DEPTH(`PPP_FIFO_DEPTH)) u_fifo (
    .clock(clock),
    .reset(reset),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out)
  );

  // Load decode and programming sequencer.
  always_comb begin
    next_command = command;
    next_addr_lo = addr_lo;
    next_addr_hi = addr_hi;
    next_dat_lo = dat_lo;
    next_dat_hi = dat_hi;
    next_state = state;
    next_timer = timer;
    next_wcnt = wcnt;
    next_fuse_sel = fuse_sel;
    next_fuse_low = fuse_low;
    next_fuse_high = fuse_high;
    next_fuse_ext = fuse_ext;
    next_lock_bits = lock_bits;
    // Loads during busy are ignored; the programmer must wait for ready.
    if (load_pulse && ready_busy_flag) begin
      unique case ({action_select_hi, action_select_lo})
        `PPP_ACT_CMD: next_command = data_in;
        // The address high byte stays until reloaded, so a new page needs only one load.
        `PPP_ACT_ADDR: begin
          if (byte_select_one) next_addr_hi = data_in;
          else next_addr_lo = data_in;
        end
        `PPP_ACT_DATA: begin
          if (byte_select_one) next_dat_hi = data_in;
          else next_dat_lo = data_in;
        end
        `PPP_ACT_IDLE: next_command = command;
      endcase
    end

    // Writes start only from idle and only for a write command; others are ignored.
    unique case (state)
      ppp_pkg::PPP_IDLE: begin
        if (write_pulse && ready_busy_flag) begin
          if (command == `PPP_CMD_WR_FLASH) begin
            next_state = ppp_pkg::PPP_WR_FLASH;
            next_timer = T_FLASH;
            next_wcnt = '0;
          end else if (command == `PPP_CMD_WR_EEPROM && !byte_select_one) begin
            next_state = ppp_pkg::PPP_WR_EEPROM;
            next_timer = T_EEPROM;
            next_wcnt = '0;
          end else if (command == `PPP_CMD_WR_FUSE) begin
            next_state = ppp_pkg::PPP_WR_FUSE;
            next_timer = T_FUSE;
            next_fuse_sel = {byte_select_two, byte_select_one};
          end else if (command == `PPP_CMD_WR_LOCK) begin
            next_state = ppp_pkg::PPP_WR_LOCK;
            next_timer = T_FUSE;
          end
        end
      end
      ppp_pkg::PPP_WR_FLASH, ppp_pkg::PPP_WR_EEPROM: begin
        // The page copy walks one word per cycle while the timer runs.
        if (copying(state, ppp_pkg::PPP_WR_FLASH, wcnt, FPAGE_W))
          next_wcnt = wcnt + 1'b1;
        else if (copying(state, ppp_pkg::PPP_WR_EEPROM, wcnt, EPAGE_W))
          next_wcnt = wcnt + 1'b1;
        // Busy lasts exactly the programming time, counted from the write edge.
        next_timer = timer - 32'h1;
        if (timer == 32'h1) next_state = ppp_pkg::PPP_IDLE;
      end
      ppp_pkg::PPP_WR_FUSE: begin
        // The fuse byte changes only when the write completes, together with ready.
        next_timer = timer - 32'h1;
        if (timer == 32'h1) begin
          next_state = ppp_pkg::PPP_IDLE;
          // Both selects high is not a listed target; it is folded onto the extended byte.
          unique case (fuse_sel)
            2'h0: next_fuse_low = dat_lo;
            2'h1: next_fuse_high = dat_lo;
            2'h2, 2'h3: next_fuse_ext = dat_lo;
          endcase
        end
      end
      ppp_pkg::PPP_WR_LOCK: begin
        next_timer = timer - 32'h1;
        if (timer == 32'h1) begin
          next_state = ppp_pkg::PPP_IDLE;
          // In lock mode 3 the boot bits are forced high in the data and keep their state.
          if (!lock_bits[`PPP_LOCK_LB1] && !lock_bits[`PPP_LOCK_LB2])
            next_lock_bits = lock_bits & (dat_lo | `PPP_LOCK_BOOT_MASK);
          else
            next_lock_bits = lock_bits & dat_lo;
        end
      end
      default: next_state = ppp_pkg::PPP_IDLE;
    endcase

    // Loads are refused while busy, so a NOP that arrives here finds the sequencer idle.
    if (next_command == `PPP_CMD_NOP && command != `PPP_CMD_NOP) begin
      next_state = ppp_pkg::PPP_IDLE;
      next_timer = '0;
    end
  end

  // Read data is registered, so the bus follows output enable and the selects a cycle late.
  always_comb begin
    next_data_oe = !output_enable_n;
    next_data_out = 8'h00;
    unique case (command)
      `PPP_CMD_RD_FLASH: begin
        if (byte_select_one) next_data_out = flash[word_addr[FLASH_AW-1:0]][15:8];
        else next_data_out = flash[word_addr[FLASH_AW-1:0]][7:0];
      end
      // A high byte select during an EEPROM read yields zero.
      `PPP_CMD_RD_EEPROM: begin
        if (!byte_select_one) next_data_out = eeprom[word_addr[EE_AW-1:0]];
      end
      `PPP_CMD_RD_FUSELOCK: begin
        unique case ({byte_select_two, byte_select_one})
          2'h0: next_data_out = fuse_low;
          2'h3: next_data_out = fuse_high;
          2'h2: next_data_out = fuse_ext;
          2'h1: next_data_out = lock_bits;
        endcase
      end
      default: next_data_out = 8'h00;
    endcase
    // Ready comes from the next state, so busy shows at the same clock edge that takes the write.
    next_ready = (next_state == ppp_pkg::PPP_IDLE);
  end

  // Every output of the port is registered here and comes straight from a flip-flop.
  always_ff @(posedge clock) begin
    if (reset) begin
      command <= `PPP_CMD_NOP;
      addr_lo <= 8'h00;
      addr_hi <= 8'h00;
      dat_lo <= 8'hFF;
      dat_hi <= 8'hFF;
      strobe_q <= 1'b0;
      latch_q <= 1'b0;
      write_q <= 1'b1;
      state <= ppp_pkg::PPP_IDLE;
      timer <= '0;
      wcnt <= '0;
      fuse_sel <= 2'h0;
      fuse_low <= `PPP_FUSE_LO_RST;
      fuse_high <= `PPP_FUSE_HI_RST;
      fuse_ext <= `PPP_FUSE_EX_RST;
      lock_bits <= `PPP_LOCK_RST;
      data_out <= 8'h00;
      data_oe <= 1'b0;
      ready_busy_flag <= 1'b1;
    end else begin
      command <= next_command;
      addr_lo <= next_addr_lo;
      addr_hi <= next_addr_hi;
      dat_lo <= next_dat_lo;
      dat_hi <= next_dat_hi;
      strobe_q <= action_strobe;
      latch_q <= page_latch_strobe;
      write_q <= write_n;
      state <= next_state;
      timer <= next_timer;
      wcnt <= next_wcnt;
      fuse_sel <= next_fuse_sel;
      fuse_low <= next_fuse_low;
      fuse_high <= next_fuse_high;
      fuse_ext <= next_fuse_ext;
      lock_bits <= next_lock_bits;
      data_out <= next_data_out;
      data_oe <= next_data_oe;
      ready_busy_flag <= next_ready;
    end
  end

  // Memory arrays and page buffers carry no reset; erased state is not modelled.
  always_ff @(posedge clock) begin
    // Every latch fills both buffers; only the page that is written afterwards matters.
    if (fifo_out_valid) begin
      fbuf[fifo_out.word[FPAGE_W-1:0]] <= fifo_out.data;
      ebuf[fifo_out.word[EPAGE_W-1:0]] <= fifo_out.data[7:0];
    end
    if (copying(state, ppp_pkg::PPP_WR_FLASH, wcnt, FPAGE_W))
      flash[{word_addr[FLASH_AW-1:FPAGE_W], wcnt[FPAGE_W-1:0]}] <= fbuf[wcnt[FPAGE_W-1:0]];
    if (copying(state, ppp_pkg::PPP_WR_EEPROM, wcnt, EPAGE_W))
      eeprom[{word_addr[EE_AW-1:EPAGE_W], wcnt[EPAGE_W-1:0]}] <= ebuf[wcnt[EPAGE_W-1:0]];
  end
endmodule // ppp_port

// ### tb/ppp_port_sva.sv
/*
  Checker of the programming port: busy timing, bus drive, write start, lock and fuse rules.
  Assumes it is bound to every ppp_port instance and sees only its pins.
*/
`timescale 1ns/1ps
`include "ppp_consts.svh"
module ppp_port_sva #(
  parameter int T_FLASH = 20,
  parameter int T_EEPROM = 20,
  parameter int T_FUSE = 20
) (
  input wire logic clock, // Clock.
  input wire logic reset, // Synchronous reset.
  input wire logic action_select_hi, // Action bit 1.
  input wire logic action_select_lo, // Action bit 0.
  input wire logic action_strobe, // Load strobe.
  input wire logic byte_select_one, // Byte select one.
  input wire logic write_n, // Write strobe.
  input wire logic output_enable_n, // Output enable.
  input wire logic [7:0] data_in, // Bus input.
  input wire logic data_oe, // Bus drive enable.
  input wire logic ready_busy_flag, // Ready flag.
  input wire logic [7:0] fuse_low, // Fuse low.
  input wire logic [7:0] fuse_high, // Fuse high.
  input wire logic [7:0] fuse_ext, // Fuse extended.
  input wire logic [7:0] lock_bits // Lock byte.
);
  localparam int T_A = (T_FLASH > T_EEPROM) ? T_FLASH : T_EEPROM;
  localparam int T_TOP = (T_A > T_FUSE) ? T_A : T_FUSE;
  logic strobe_q;
  logic [7:0] cmd;
  int busy_cnt;
  logic wr_ok;
  // The command is tracked here so that write starts can be judged without the body.
  always_ff @(posedge clock) begin
    strobe_q <= reset ? 1'b0 : action_strobe;
    busy_cnt <= (reset || ready_busy_flag) ? 0 : busy_cnt + 1;
    if (reset) begin
      cmd <= `PPP_CMD_NOP;
    end else if (action_strobe && !strobe_q && ready_busy_flag && action_select_hi
                 && !action_select_lo) begin
      cmd <= data_in;
    end
  end
  assign wr_ok = cmd == `PPP_CMD_WR_FLASH || cmd == `PPP_CMD_WR_FUSE || cmd == `PPP_CMD_WR_LOCK
                 || (cmd == `PPP_CMD_WR_EEPROM && !byte_select_one);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  property p_oe;
    !$past(reset) |-> data_oe == !$past(output_enable_n);
  endproperty
  a_oe: assert property (p_oe) else $error("bus drive does not follow output enable");
  property p_start;
    $fell(write_n) && ready_busy_flag && wr_ok |=> !ready_busy_flag;
  endproperty
  a_start: assert property (p_start) else $error("write did not start busy");
  property p_no_start;
    $fell(write_n) && ready_busy_flag && !wr_ok |=> ready_busy_flag;
  endproperty
  a_no_start: assert property (p_no_start) else $error("write ran without command");
  property p_busy_len;
    $rose(ready_busy_flag) |-> busy_cnt == T_FLASH || busy_cnt == T_EEPROM || busy_cnt == T_FUSE;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
  property p_busy_max;
    !ready_busy_flag |-> busy_cnt < T_TOP;
  endproperty
  a_busy_max: assert property (p_busy_max) else $error("busy too long");
  property p_lock_keep;
    !$past(reset) |-> (lock_bits & ~$past(lock_bits)) == 8'h00;
  endproperty
  a_lock_keep: assert property (p_lock_keep) else $error("lock bit erased");
  property p_boot;
    !$past(reset) && !$past(lock_bits[`PPP_LOCK_LB1]) && !$past(lock_bits[`PPP_LOCK_LB2])
      |-> (lock_bits & `PPP_LOCK_BOOT_MASK) == ($past(lock_bits) & `PPP_LOCK_BOOT_MASK);
  endproperty
  a_boot: assert property (p_boot) else $error("boot lock changed in mode 3");
  property p_quiet;
    !$past(reset) && $past(ready_busy_flag) && ready_busy_flag
      |-> $stable({fuse_low, fuse_high, fuse_ext, lock_bits});
  endproperty
  a_quiet: assert property (p_quiet) else $error("fuse or lock changed while idle");
  c_flash: cover property ($fell(write_n) && ready_busy_flag && cmd == `PPP_CMD_WR_FLASH);
  c_fuse_rd: cover property (data_oe && cmd == `PPP_CMD_RD_FUSELOCK);
  c_mode3: cover property (!lock_bits[`PPP_LOCK_LB1] && !lock_bits[`PPP_LOCK_LB2]);
endmodule // ppp_port_sva

bind ppp_port ppp_port_sva #(.T_FLASH(T_FLASH), .T_EEPROM(T_EEPROM), .T_FUSE(T_FUSE)) u_sva (
  .clock(clock), .reset(reset), .action_select_hi(action_select_hi),
  .action_select_lo(action_select_lo), .action_strobe(action_strobe),
  .byte_select_one(byte_select_one), .write_n(write_n), .output_enable_n(output_enable_n),
  .data_in(data_in), .data_oe(data_oe), .ready_busy_flag(ready_busy_flag),
  .fuse_low(fuse_low), .fuse_high(fuse_high), .fuse_ext(fuse_ext), .lock_bits(lock_bits));

// ### tb/ppp_prog_bus.sv
/*
  Programmer side of the byte bus: resolves who drives it.
  Assumes the bench never drives while the port drives.
*/
`timescale 1ns/1ps
module ppp_prog_bus (
  input wire logic clock, // Clock.
  input wire logic drive_en, // Programmer drives.
  input wire logic [7:0] drive_val, // Programmer byte.
  input wire logic [7:0] data_out, // Port byte.
  input wire logic data_oe, // Port drives.
  output logic [7:0] bus // Bus level.
);
  logic [7:0] last;
  // No pull resistor: a released bus toggles so a stale byte never passes for a read.
  always_comb begin
    if (drive_en) begin
      bus = drive_val;
    end else if (data_oe) begin
      bus = data_out;
    end else begin
      bus = ~last;
    end
  end
  always_ff @(posedge clock) begin
    last <= bus;
  end
endmodule // ppp_prog_bus

// ### tb/ppp_port_bench.sv
/*
  Self-checking bench of the programming port: flash, EEPROM, fuse and lock traffic.
  Assumes the checker is bound by its own file.
*/
`timescale 1ns/1ps
`include "ppp_consts.svh"
module ppp_port_bench;
  // Flash busy time must be at least the 64-word page copy, or high words are never written.
  localparam int TF = 80;
  localparam int TE = 16;
  localparam int TU = 12;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic sel_hi = 1'b1, sel_lo = 1'b1, strobe = 1'b0, bs1 = 1'b0, bs2 = 1'b0, latch = 1'b0;
  logic write_n = 1'b1, oe_n = 1'b1, prog_en = 1'b0, data_oe, ready;
  logic [7:0] prog_val = 8'h00, bus, data_out, fuse_low, fuse_high, fuse_ext, lock_bits;
  logic [7:0] pg, exp_lock, ee [4], fz [3];
  logic [15:0] fw [4];
  logic [5:0] wd [4] = '{6'h00, 6'h01, 6'h02, 6'h3F};
  logic [7:0] lk [4] = '{8'hF7, 8'hFF, 8'hFC, 8'hC3};
  int error_cnt = 0, checked = 0;
  ppp_port #(.T_FLASH(TF), .T_EEPROM(TE), .T_FUSE(TU)) DUT (
    .clock(clock), .reset(reset), .action_select_hi(sel_hi), .action_select_lo(sel_lo),
    .action_strobe(strobe), .byte_select_one(bs1), .byte_select_two(bs2),
    .page_latch_strobe(latch), .write_n(write_n), .output_enable_n(oe_n), .data_in(bus),
    .data_out(data_out), .data_oe(data_oe), .ready_busy_flag(ready), .fuse_low(fuse_low),
    .fuse_high(fuse_high), .fuse_ext(fuse_ext), .lock_bits(lock_bits));
  ppp_prog_bus u_bus (.clock(clock), .drive_en(prog_en), .drive_val(prog_val),
    .data_out(data_out), .data_oe(data_oe), .bus(bus));
  initial begin
    forever #50 clock = ~clock;
  end
  function automatic logic [7:0] next_lock(input logic [7:0] old, input logic [7:0] d);
    return old & ((!old[0] && !old[1]) ? (d | `PPP_LOCK_BOOT_MASK) : d);
  endfunction
  task automatic finish_test();
    $display("Checks %0d, errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic load(input logic [1:0] act, input logic b1, input logic [7:0] v);
    @(posedge clock);
    {sel_hi, sel_lo} <= act;
    bs1 <= b1;
    prog_en <= 1'b1;
    prog_val <= v;
    @(posedge clock);
    strobe <= 1'b1;
    @(posedge clock);
    strobe <= 1'b0;
  endtask
  task automatic put_latch();
    @(posedge clock);
    bs1 <= 1'b1;
    latch <= 1'b1;
    @(posedge clock);
    latch <= 1'b0;
  endtask
  task automatic wr(input logic b1, input logic b2, input int t_exp);
    int n;
    n = 0;
    @(posedge clock);
    bs1 <= b1;
    bs2 <= b2;
    write_n <= 1'b0;
    @(posedge clock);
    write_n <= 1'b1;
    // The edge that takes the write is this one, so busy is counted from here.
    #1;
    if (ready === 1'b0) n++;
    for (int i = 0; i < 120; i++) begin
      @(posedge clock);
      #1;
      if (ready === 1'b0) n++;
      else if (n > 0) break;
    end
    chk("busy cycles", 16'(n), 16'(t_exp));
    chk("ready", {15'h0000, ready}, 16'h0001);
    if (ready !== 1'b1) finish_test();
  endtask
  task automatic rd(input logic b1, input logic b2, input logic [7:0] exp, input string name);
    @(posedge clock);
    prog_en <= 1'b0;
    bs1 <= b1;
    bs2 <= b2;
    oe_n <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    chk("drive enable", {15'h0000, data_oe}, 16'h0001);
    chk(name, {8'h00, bus}, {8'h00, exp});
    @(posedge clock);
    oe_n <= 1'b1;
  endtask
  initial begin
    pg = 8'($urandom(73));
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    #1;
    chk("fuses", {fuse_low, fuse_high}, {`PPP_FUSE_LO_RST, `PPP_FUSE_HI_RST});
    chk("ext lock", {fuse_ext, lock_bits}, {`PPP_FUSE_EX_RST, `PPP_LOCK_RST});
    pg = 8'($urandom);
    load(`PPP_ACT_CMD, 1'b0, `PPP_CMD_WR_FLASH);
    for (int i = 0; i < 4; i++) begin
      fw[i] = 16'($urandom);
      load(`PPP_ACT_ADDR, 1'b0, {pg[7:6], wd[i]});
      load(`PPP_ACT_DATA, 1'b0, fw[i][7:0]);
      load(`PPP_ACT_DATA, 1'b1, fw[i][15:8]);
      put_latch();
    end
    load(`PPP_ACT_ADDR, 1'b1, pg);
    wr(1'b0, 1'b0, TF);
    load(`PPP_ACT_CMD, 1'b0, `PPP_CMD_NOP);
    wr(1'b0, 1'b0, 0);
    load(`PPP_ACT_CMD, 1'b0, `PPP_CMD_RD_FLASH);
    for (int i = 0; i < 4; i++) begin
      load(`PPP_ACT_ADDR, 1'b0, {pg[7:6], wd[i]});
      rd(1'b0, 1'b0, fw[i][7:0], "flash low");
      rd(1'b1, 1'b0, fw[i][15:8], "flash high");
    end
    load(`PPP_ACT_CMD, 1'b0, `PPP_CMD_WR_EEPROM);
    load(`PPP_ACT_ADDR, 1'b1, pg);
    for (int i = 0; i < 4; i++) begin
      ee[i] = 8'($urandom);
      load(`PPP_ACT_ADDR, 1'b0, {pg[7:2], 2'(i)});
      load(`PPP_ACT_DATA, 1'b0, ee[i]);
      put_latch();
    end
    wr(1'b1, 1'b0, 0);
    wr(1'b0, 1'b0, TE);
    load(`PPP_ACT_CMD, 1'b0, `PPP_CMD_RD_EEPROM);
    for (int i = 0; i < 4; i++) begin
      load(`PPP_ACT_ADDR, 1'b0, {pg[7:2], 2'(i)});
      rd(1'b0, 1'b0, ee[i], "eeprom");
    end
    load(`PPP_ACT_CMD, 1'b0, `PPP_CMD_WR_FUSE);
    for (int i = 0; i < 3; i++) begin
      fz[i] = 8'($urandom);
      load(`PPP_ACT_DATA, 1'b0, fz[i]);
      wr(i == 1, i == 2, TU);
    end
    chk("fuse low high", {fuse_low, fuse_high}, {fz[0], fz[1]});
    chk("fuse ext", {8'h00, fuse_ext}, {8'h00, fz[2]});
    exp_lock = `PPP_LOCK_RST;
    load(`PPP_ACT_CMD, 1'b0, `PPP_CMD_WR_LOCK);
    for (int i = 0; i < 4; i++) begin
      load(`PPP_ACT_DATA, 1'b0, lk[i]);
      wr(1'b0, 1'b0, TU);
      exp_lock = next_lock(exp_lock, lk[i]);
      chk("lock", {8'h00, lock_bits}, {8'h00, exp_lock});
    end
    load(`PPP_ACT_CMD, 1'b0, `PPP_CMD_RD_FUSELOCK);
    rd(1'b0, 1'b0, fz[0], "read fuse low");
    rd(1'b1, 1'b1, fz[1], "read fuse high");
    rd(1'b0, 1'b1, fz[2], "read fuse ext");
    rd(1'b1, 1'b0, exp_lock, "read lock");
    wr(1'b0, 1'b0, 0);
    @(posedge clock);
    reset <= 1'b1;
    @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    #1;
    chk("fuses again", {fuse_low, fuse_ext}, {`PPP_FUSE_LO_RST, `PPP_FUSE_EX_RST});
    finish_test();
  end
endmodule // ppp_port_bench
